// File: sdo_pkg.sv
// constants, frame types and object-dictionary handshake types for the service-data server
// Functional notes
// - long objects travel as segments (only uploads here; downloads must be expedited); every request except a client abort gets its own response
// - normal upload init reply carries total size in data bytes, not in command
// - normal upload init reply is 41, echoes index/subindex, size little-endian
// - toggle alternates per segment request, starts at zero on every transfer
// - segment response repeats the toggle of the request it answers
// - segment response holds up to seven bytes; bits 3..1 count unused bytes
// - more-segments-complete bit is one only in the final segment response
// - segment commands: 00 full toggle clear, 10 toggle set, 09 last with four unused
// - every request and response is exactly eight bytes, unused bytes zero
// - either side may abort; unconfirmed, transfer ends on receipt
// - after abort a fresh initiation is needed; client abort code is ignored
// - segment request whose toggle did not alternate aborts with 05030000
// - command byte that is not permitted aborts with 05040001
// - write to read-only gives 06010002; unsupported complete access gives 06010000
// - missing index gives 06020000; missing subindex gives 06090011
// - unmappable object gives 06040041; mapping over eight bytes gives 06040042
// - write announcing too much data gives 06070012, too little 06070013
// - value too high 06090031, too low 06090032; error count accepts only zero
// - writes to process-data parameter objects while operational abort with 08000022
// - failures matching no other category abort with 08000000
// - string objects readable one character per subindex from subindex 1 upward
// - requests on 600h plus node id, replies on 580h plus node id
package sdo_pkg;
    localparam logic [10:0] SDO_REQ_BASE = 11'h600;
    localparam logic [10:0] SDO_RSP_BASE = 11'h580;
    localparam int SDO_FRAME_BYTES = 8;
    localparam int SDO_SEG_MAX = 7;
    localparam int SDO_EXP_MAX = 4;
    // client command specifiers in bits 7..5
    localparam logic [2:0] SDO_CCS_DL_INIT = 3'h1;
    localparam logic [2:0] SDO_CCS_UP_INIT = 3'h2;
    localparam logic [2:0] SDO_CCS_UP_SEG = 3'h3;
    localparam logic [2:0] SDO_CCS_ABORT = 3'h4;
    // command byte bit positions
    localparam int SDO_TOG_BIT = 4;
    localparam int SDO_CA_BIT = 4;
    localparam int SDO_EXP_BIT = 1;
    localparam int SDO_SZ_BIT = 0;
    // server command bytes
    localparam logic [7:0] SDO_CMD_UP_INIT_SEG = 8'h41;
    localparam logic [7:0] SDO_CMD_UP_EXP = 8'h43;
    localparam logic [7:0] SDO_CMD_DL_ACK = 8'h60;
    localparam logic [7:0] SDO_CMD_ABORT = 8'h80;
    // abort codes
    localparam logic [31:0] SDO_AB_TOGGLE = 32'h05030000;
    localparam logic [31:0] SDO_AB_CMD = 32'h05040001;
    localparam logic [31:0] SDO_AB_ACCESS = 32'h06010000;
    localparam logic [31:0] SDO_AB_RDONLY = 32'h06010002;
    localparam logic [31:0] SDO_AB_NO_OBJ = 32'h06020000;
    localparam logic [31:0] SDO_AB_NO_MAP = 32'h06040041;
    localparam logic [31:0] SDO_AB_MAP_LEN = 32'h06040042;
    localparam logic [31:0] SDO_AB_LONG = 32'h06070012;
    localparam logic [31:0] SDO_AB_SHORT = 32'h06070013;
    localparam logic [31:0] SDO_AB_NO_SUB = 32'h06090011;
    localparam logic [31:0] SDO_AB_HIGH = 32'h06090031;
    localparam logic [31:0] SDO_AB_LOW = 32'h06090032;
    localparam logic [31:0] SDO_AB_GENERAL = 32'h08000000;
    localparam logic [31:0] SDO_AB_STATE = 32'h08000022;
    // process-data parameter object groups, eight objects each
    localparam logic [15:0] SDO_RXCOM_IDX = 16'h1400;
    localparam logic [15:0] SDO_RXMAP_IDX = 16'h1600;
    localparam logic [15:0] SDO_TXCOM_IDX = 16'h1800;
    localparam logic [15:0] SDO_TXMAP_IDX = 16'h1a00;
    localparam logic [15:0] SDO_PDO_MASK = 16'hfff8;
    localparam logic [15:0] SDO_ERRCNT_IDX = 16'h1003;
    localparam logic [7:0] SDO_ERRCNT_SUB = 8'h00;

    typedef struct packed {
        logic [10:0] cob_id;
        logic [7:0][7:0] data;   // data[0] is the command byte
    } sdo_frame_t;

    typedef enum logic [3:0] {
        SDO_OD_OK, SDO_OD_NO_INDEX, SDO_OD_NO_SUB, SDO_OD_RDONLY, SDO_OD_ACCESS,
        SDO_OD_NO_MAP, SDO_OD_MAP_LEN, SDO_OD_LONG, SDO_OD_SHORT,
        SDO_OD_HIGH, SDO_OD_LOW, SDO_OD_GENERAL
    } sdo_od_status_t;

    typedef struct packed {
        logic [15:0] index;
        logic [7:0] subidx;
        logic write;
        logic [2:0] len;         // bytes announced by a write, 1..4
        logic [31:0] wdata;
    } sdo_od_req_t;

    typedef struct packed {
        sdo_od_status_t status;
        logic [31:0] size;       // object size in bytes for a read
        logic [31:0] rdata;      // value for reads of up to four bytes
    } sdo_od_rsp_t;
endpackage

// File: sdo_seg_mem.sv
// byte buffer holding the object image that a segmented upload reads out
`timescale 1ns/100ps
`default_nettype none
module sdo_seg_mem #(
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    // clock
    input wire logic mclk,
    // load port from the application
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    // read port, one cycle latency
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [DEPTH];

    // no reset on the array so it maps onto block memory
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // registered read data
    always_ff @(posedge mclk) begin
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

// File: sdo_server.sv
// service-data server: request decode, object lookup, segmented upload and aborts
`timescale 1ns/100ps
`default_nettype none
module sdo_server #(
    parameter int MEM_DEPTH = 256,
    parameter int MEM_AW = 8
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // node configuration
    input wire logic [6:0] node_id,
    input wire logic nmt_operational,
    // request frames from the bus
    input wire logic rx_valid,
    input wire sdo_pkg::sdo_frame_t rx_frame,
    output logic rx_ready,
    // response frames to the bus
    output logic tx_valid,
    output sdo_pkg::sdo_frame_t tx_frame,
    input wire logic tx_ready,
    // object dictionary lookup
    output logic od_req,
    output sdo_pkg::sdo_od_req_t od_info,
    input wire logic od_ack,
    input wire sdo_pkg::sdo_od_rsp_t od_rsp,
    // upload image load port
    input wire logic ld_we,
    input wire logic [MEM_AW-1:0] ld_addr,
    input wire logic [7:0] ld_data
);
    import sdo_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_LOOKUP, ST_FETCH, ST_SEND} sdo_state_t;
    typedef enum logic [2:0] {ACT_NONE, ACT_DROP, ACT_ABORT, ACT_LOOKUP, ACT_SEG} sdo_act_t;
    localparam logic [31:0] MEM_SIZE = 32'(MEM_DEPTH);
    localparam logic [31:0] SEG_MAX = 32'(SDO_SEG_MAX);
    localparam logic [31:0] EXP_MAX = 32'(SDO_EXP_MAX);
    localparam logic [2:0] FETCH_LAST = 3'(SDO_SEG_MAX);

    sdo_state_t state, next_state;
    sdo_act_t act;
    logic take, pdo_obj, up_active, exp_tog, seg_last, seg_rsp, req_tog;
    logic [7:0] cmd, req_sub, cur_sub, rd_data;
    logic [15:0] req_idx, cur_idx;
    logic [31:0] req_val, act_code, od_code, obj_size, pos, rem;
    logic [2:0] req_len, seg_n, fcnt;
    logic [MEM_AW-1:0] rd_addr;

    // frames for us arrive on the request identifier of this node
    assign take = rx_valid && rx_ready && (rx_frame.cob_id == SDO_REQ_BASE + 11'(node_id));
    assign cmd = rx_frame.data[0];
    assign req_idx = {rx_frame.data[2], rx_frame.data[1]};
    assign req_sub = rx_frame.data[3];
    assign req_val = {rx_frame.data[7], rx_frame.data[6], rx_frame.data[5], rx_frame.data[4]};
    // expedited write length: four minus the unused count when size is indicated
    assign req_len = cmd[SDO_SZ_BIT] ? 3'(3'd4 - {1'b0, cmd[3:2]}) : 3'd4;
    assign pdo_obj = ((req_idx & SDO_PDO_MASK) == SDO_RXCOM_IDX)
        || ((req_idx & SDO_PDO_MASK) == SDO_RXMAP_IDX)
        || ((req_idx & SDO_PDO_MASK) == SDO_TXCOM_IDX)
        || ((req_idx & SDO_PDO_MASK) == SDO_TXMAP_IDX);

    // classify an incoming request; any abort also ends a running upload
    always_comb begin
        act = ACT_NONE;
        act_code = SDO_AB_GENERAL;
        if (take) begin
            case (cmd[7:5])
                SDO_CCS_ABORT: act = ACT_DROP;                 // code ignored
                SDO_CCS_UP_SEG: begin
                    if (!up_active) begin
                        act = ACT_ABORT;
                        act_code = SDO_AB_CMD;
                    end else if (cmd[SDO_TOG_BIT] != exp_tog) begin
                        act = ACT_ABORT;
                        act_code = SDO_AB_TOGGLE;
                    end else begin
                        act = ACT_SEG;
                    end
                end
                SDO_CCS_UP_INIT: begin
                    if (cmd[SDO_CA_BIT]) begin
                        act = ACT_ABORT;
                        act_code = SDO_AB_ACCESS;
                    end else begin
                        act = ACT_LOOKUP;
                    end
                end
                SDO_CCS_DL_INIT: begin
                    if (!cmd[SDO_EXP_BIT]) begin
                        act = ACT_ABORT;
                        act_code = SDO_AB_CMD;
                    end else if (nmt_operational && pdo_obj) begin
                        act = ACT_ABORT;
                        act_code = SDO_AB_STATE;
                    end else if (req_idx == SDO_ERRCNT_IDX && req_sub == SDO_ERRCNT_SUB
                                 && req_val != 32'h0) begin
                        act = ACT_ABORT;
                        act_code = SDO_AB_HIGH;
                    end else begin
                        act = ACT_LOOKUP;
                    end
                end
                default: begin
                    act = ACT_ABORT;
                    act_code = SDO_AB_CMD;
                end
            endcase
        end
    end

    // dictionary answer to abort code
    always_comb begin
        case (od_rsp.status)
            SDO_OD_NO_INDEX: od_code = SDO_AB_NO_OBJ;
            SDO_OD_NO_SUB: od_code = SDO_AB_NO_SUB;
            SDO_OD_RDONLY: od_code = SDO_AB_RDONLY;
            SDO_OD_ACCESS: od_code = SDO_AB_ACCESS;
            SDO_OD_NO_MAP: od_code = SDO_AB_NO_MAP;
            SDO_OD_MAP_LEN: od_code = SDO_AB_MAP_LEN;
            SDO_OD_LONG: od_code = SDO_AB_LONG;
            SDO_OD_SHORT: od_code = SDO_AB_SHORT;
            SDO_OD_HIGH: od_code = SDO_AB_HIGH;
            SDO_OD_LOW: od_code = SDO_AB_LOW;
            default: od_code = SDO_AB_GENERAL;
        endcase
    end

    // remaining bytes decide segment fill and the final flag
    assign rem = obj_size - pos;
    assign seg_last = (rem <= SEG_MAX);
    assign seg_n = seg_last ? rem[2:0] : 3'(SDO_SEG_MAX);
    assign rd_addr = MEM_AW'(pos + 32'(fcnt));

    sdo_seg_mem #(.DEPTH(MEM_DEPTH), .AW(MEM_AW)) u_mem (
        .mclk(mclk),
        .wr_en(ld_we),
        .wr_addr(ld_addr),
        .wr_data(ld_data),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    // sequencing; requests are refused while a reply is still being built
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (act == ACT_LOOKUP) next_state = ST_LOOKUP;
                else if (act == ACT_SEG) next_state = ST_FETCH;
                else if (act == ACT_ABORT) next_state = ST_SEND;
            end
            ST_LOOKUP: if (od_ack) next_state = ST_SEND;
            ST_FETCH: if (fcnt == FETCH_LAST) next_state = ST_SEND;
            ST_SEND: if (tx_ready) next_state = ST_IDLE;        // one reply per request
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            rx_ready <= 1'b0;
            tx_valid <= 1'b0;
        end else begin
            state <= next_state;
            rx_ready <= (next_state == ST_IDLE);
            tx_valid <= (next_state == ST_SEND);
        end
    end

    // lookup request, a single pulse on entry
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            od_req <= 1'b0;
            od_info <= '0;
        end else begin
            od_req <= (act == ACT_LOOKUP);
            if (act == ACT_LOOKUP) begin
                // a string element is just another subindex here
                od_info <= '{index: req_idx, subidx: req_sub,
                             write: (cmd[7:5] == SDO_CCS_DL_INIT), len: req_len,
                             wdata: req_val};
            end
        end
    end

    // fetch counter walks eight cycles: seven addresses, one read latency
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            fcnt <= 3'h0;
        end else if (state == ST_FETCH) begin
            fcnt <= fcnt + 3'h1;
        end else begin
            fcnt <= 3'h0;
        end
    end

    // upload transfer state: toggle, position, size
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            up_active <= 1'b0;
            exp_tog <= 1'b0;
            cur_idx <= 16'h0;
            cur_sub <= 8'h0;
            obj_size <= 32'h0;
            pos <= 32'h0;
        end else if (act == ACT_DROP || act == ACT_ABORT || act == ACT_LOOKUP) begin
            up_active <= 1'b0;                                 // fresh init needed
            exp_tog <= 1'b0;
            if (act == ACT_LOOKUP) begin
                cur_idx <= req_idx;
                cur_sub <= req_sub;
            end
        end else if (state == ST_LOOKUP && od_ack && !od_info.write
                     && od_rsp.status == SDO_OD_OK && od_rsp.size > EXP_MAX
                     && od_rsp.size <= MEM_SIZE) begin
            up_active <= 1'b1;                                 // segmented path
            exp_tog <= 1'b0;
            obj_size <= od_rsp.size;
            pos <= 32'h0;
        end else if (state == ST_FETCH && fcnt == FETCH_LAST) begin
            pos <= pos + 32'(seg_n);
            exp_tog <= ~exp_tog;
            if (seg_last) up_active <= 1'b0;
        end
    end

    // response frame; unused bytes stay zero so every frame is eight bytes
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tx_frame <= '0;
            seg_rsp <= 1'b0;
            req_tog <= 1'b0;
        end else if (act == ACT_ABORT) begin
            tx_frame.cob_id <= SDO_RSP_BASE + 11'(node_id);
            tx_frame.data[0] <= SDO_CMD_ABORT;
            tx_frame.data[2] <= (cmd[7:5] == SDO_CCS_UP_SEG) ? cur_idx[15:8] : req_idx[15:8];
            tx_frame.data[1] <= (cmd[7:5] == SDO_CCS_UP_SEG) ? cur_idx[7:0] : req_idx[7:0];
            tx_frame.data[3] <= (cmd[7:5] == SDO_CCS_UP_SEG) ? cur_sub : req_sub;
            tx_frame.data[7:4] <= act_code;                    // low byte lands in byte 4
            seg_rsp <= 1'b0;
        end else if (act == ACT_SEG) begin
            tx_frame.cob_id <= SDO_RSP_BASE + 11'(node_id);
            tx_frame.data <= '0;
            req_tog <= cmd[SDO_TOG_BIT];
            seg_rsp <= 1'b1;
        end else if (state == ST_FETCH) begin
            if (fcnt != 3'h0 && fcnt <= seg_n) begin
                tx_frame.data[fcnt] <= rd_data;
            end
            if (fcnt == FETCH_LAST) begin
                // toggle echoed, unused count in bits 3..1, last flag in bit 0
                tx_frame.data[0] <= {3'b000, exp_tog, 3'(3'd7 - seg_n), seg_last};
            end
        end else if (state == ST_LOOKUP && od_ack) begin
            tx_frame.cob_id <= SDO_RSP_BASE + 11'(node_id);
            tx_frame.data[3:1] <= {od_info.subidx, od_info.index[15:8], od_info.index[7:0]};
            seg_rsp <= 1'b0;
            if (od_rsp.status != SDO_OD_OK) begin
                tx_frame.data[0] <= SDO_CMD_ABORT;
                tx_frame.data[7:4] <= od_code;
            end else if (od_info.write) begin
                tx_frame.data[0] <= SDO_CMD_DL_ACK;
                tx_frame.data[7:4] <= '0;
            end else if (od_rsp.size == 32'h0 || od_rsp.size > MEM_SIZE) begin
                tx_frame.data[0] <= SDO_CMD_ABORT;
                tx_frame.data[7:4] <= SDO_AB_GENERAL;
            end else if (od_rsp.size <= EXP_MAX) begin
                // short objects answer at once, unused count in bits 3..2
                tx_frame.data[0] <= SDO_CMD_UP_EXP | {4'h0, 2'(3'd4 - od_rsp.size[2:0]), 2'b00};
                tx_frame.data[7:4] <= od_rsp.rdata;
            end else begin
                tx_frame.data[0] <= SDO_CMD_UP_INIT_SEG;
                tx_frame.data[7:4] <= od_rsp.size;             // size little-endian
            end
        end
    end

    // checks
    property p_rsp_id;
        @(posedge mclk) disable iff (!reset_n)
        tx_valid |-> tx_frame.cob_id == SDO_RSP_BASE + 11'(node_id);
    endproperty
    a_rsp_id: assert property (p_rsp_id) else $error("reply on wrong identifier");
    property p_seg_answer;
        @(posedge mclk) disable iff (!reset_n)
        (act == ACT_SEG) |-> ##[9:9] (tx_valid && seg_rsp);
    endproperty
    a_seg_answer: assert property (p_seg_answer) else $error("segment request unanswered");
    property p_init_size;
        @(posedge mclk) disable iff (!reset_n)
        (tx_valid && !seg_rsp && tx_frame.data[0] == SDO_CMD_UP_INIT_SEG)
            |-> (tx_frame.data[7:4] == obj_size) && up_active;
    endproperty
    a_init_size: assert property (p_init_size) else $error("init reply size wrong");
    property p_tog_echo;
        @(posedge mclk) disable iff (!reset_n)
        (tx_valid && seg_rsp) |-> tx_frame.data[0][SDO_TOG_BIT] == req_tog;
    endproperty
    a_tog_echo: assert property (p_tog_echo) else $error("toggle not echoed");
    property p_full_seg;
        @(posedge mclk) disable iff (!reset_n)
        (tx_valid && seg_rsp && !tx_frame.data[0][0]) |-> tx_frame.data[0][3:1] == 3'h0;
    endproperty
    a_full_seg: assert property (p_full_seg) else $error("non-final segment not full");
    property p_last_ends;
        @(posedge mclk) disable iff (!reset_n)
        $rose(tx_valid) && seg_rsp && tx_frame.data[0][0] |-> !up_active;
    endproperty
    a_last_ends: assert property (p_last_ends) else $error("transfer still open after last");
    property p_tog_start;
        @(posedge mclk) disable iff (!reset_n)
        $rose(up_active) |-> !exp_tog;
    endproperty
    a_tog_start: assert property (p_tog_start) else $error("toggle not zero at start");
    property p_tog_abort;
        @(posedge mclk) disable iff (!reset_n)
        (act == ACT_ABORT && act_code == SDO_AB_TOGGLE)
            |=> tx_valid && tx_frame.data[0] == SDO_CMD_ABORT
                && tx_frame.data[7:4] == SDO_AB_TOGGLE;
    endproperty
    a_tog_abort: assert property (p_tog_abort) else $error("toggle error not aborted");
    property p_client_abort;
        @(posedge mclk) disable iff (!reset_n)
        (act == ACT_DROP) |=> (!up_active && !tx_valid) [*2];
    endproperty
    a_client_abort: assert property (p_client_abort) else $error("client abort not honoured");
endmodule
`default_nettype wire

// File: sdo_od_model.sv
// dictionary stand-in that answers the server's lookups
`timescale 1ns/100ps
`default_nettype none
module sdo_od_model (
    // clock
    input wire logic mclk,
    // lookup handshake
    input wire logic od_req,
    input wire sdo_pkg::sdo_od_req_t od_info,
    output logic od_ack,
    output sdo_pkg::sdo_od_rsp_t od_rsp
);
    import sdo_pkg::*;
    logic [1:0] dly = 2'h0;
    // answer two cycles late so the server really has to wait
    always_ff @(posedge mclk) begin
        dly <= {dly[0], od_req};
    end
    assign od_ack = dly[1];
    // status and size by index alone; subindex is ignored
    always_comb begin
        od_rsp = '0;
        od_rsp.size = 32'h4;
        if (od_info.index == 16'h100a) od_rsp.size = 32'h11;
        if (od_info.index == 16'h6041) od_rsp = {SDO_OD_OK, 32'h2, 32'h240};
        if (od_info.index == 16'h2000) od_rsp.status = SDO_OD_NO_INDEX;
        // oversized image, too-long write and unmappable object stand-ins
        if (od_info.index == 16'h2001) od_rsp.size = 32'h1000;
        if (od_info.index == 16'h2003) od_rsp.status = SDO_OD_LONG;
        if (od_info.index == 16'h2004) od_rsp.status = SDO_OD_NO_MAP;
    end
endmodule
`default_nettype wire

// File: testbench.sv
// self-checking bench for the service-data server
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import sdo_pkg::*;
    logic mclk = 0, reset_n = 0, nmt_operational = 0, rx_valid = 0, tx_ready = 0;
    logic ld_we = 0, rx_ready, tx_valid, od_req, od_ack;
    logic [7:0] ld_addr = 8'h0, ld_data = 8'h0;
    sdo_frame_t rx_frame = '0, tx_frame;
    sdo_od_req_t od_info;
    sdo_od_rsp_t od_rsp;
    int err_count = 0, n_checks = 0;
    logic [6:0] node = 7'h03;   // node id, moved late in the run
    sdo_server dut_u (.mclk(mclk), .reset_n(reset_n), .node_id(node),
        .nmt_operational(nmt_operational), .rx_valid(rx_valid), .rx_frame(rx_frame),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_frame(tx_frame), .tx_ready(tx_ready),
        .od_req(od_req), .od_info(od_info), .od_ack(od_ack), .od_rsp(od_rsp),
        .ld_we(ld_we), .ld_addr(ld_addr), .ld_data(ld_data));
    sdo_od_model od_u (.mclk(mclk), .od_req(od_req), .od_info(od_info),
        .od_ack(od_ack), .od_rsp(od_rsp));
    initial forever #4 mclk = ~mclk;
    function automatic logic [63:0] mk(logic [7:0] c, logic [15:0] i, logic [31:0] v);
        return {v, 8'h00, i, c};
    endfunction
    // segment image bytes are 10h plus their offset
    function automatic logic [63:0] seg(logic [7:0] c, int f, int n);
        logic [63:0] d;
        d = {56'h0, c};
        for (int k = 0; k < n; k++) d[8*k+8 +: 8] = 8'h10 + 8'(f + k);
        return d;
    endfunction
    task automatic chk(string nm, logic [74:0] seen, logic [74:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // present one request until the server has taken it
    task automatic send(logic [63:0] d);
        int t = 0;
        @(negedge mclk);
        while (rx_ready !== 1'b1 && t++ < 50) @(negedge mclk);
        if (t > 50) err_count++;   // server never became ready
        rx_frame = {SDO_REQ_BASE + 11'(node), d};
        rx_valid = 1;
        @(negedge mclk);
        rx_valid = 0;
    endtask
    task automatic xfer(string nm, logic [63:0] d, logic [63:0] e);
        int t = 0;
        send(d);
        while (tx_valid !== 1'b1 && t++ < 50) @(negedge mclk);
        if (t > 50) err_count++;   // no reply in time
        chk(nm, tx_frame, {SDO_RSP_BASE + 11'(node), e});
        tx_ready = 1;
        @(negedge mclk);
        tx_ready = 0;
    endtask
    task automatic t_seg();
        xfer("init", mk(8'h40, 16'h100a, 0), mk(8'h41, 16'h100a, 32'h11));
        xfer("seg0", mk(8'h60, 16'h100a, 0), seg(8'h00, 0, 7));
        xfer("seg1", mk(8'h70, 16'h100a, 0), seg(8'h10, 7, 7));
        xfer("seg2", mk(8'h60, 16'h100a, 0), seg(8'h09, 14, 3));
        $display("test segmented upload done");
    endtask
    task automatic t_tog();
        xfer("init", mk(8'h40, 16'h100a, 0), mk(8'h41, 16'h100a, 32'h11));
        xfer("seg0", mk(8'h60, 16'h100a, 0), seg(8'h00, 0, 7));
        xfer("same", mk(8'h60, 16'h100a, 0), mk(8'h80, 16'h100a, SDO_AB_TOGGLE));
        xfer("idle", mk(8'h60, 16'h100a, 0), mk(8'h80, 16'h100a, SDO_AB_CMD));
        xfer("reinit", mk(8'h40, 16'h100a, 0), mk(8'h41, 16'h100a, 32'h11));
        xfer("fresh", mk(8'h60, 16'h100a, 0), seg(8'h00, 0, 7));
        $display("test toggle fault done");
    endtask
    // client abort mid-transfer: no reply, then the transfer is gone
    task automatic t_cabort();
        send(mk(8'h80, 16'h100a, 32'hdeadbeef));
        repeat (12) @(negedge mclk);
        chk("no reply", {74'h0, tx_valid}, 75'h0);
        xfer("after", mk(8'h70, 16'h100a, 0), mk(8'h80, 16'h100a, SDO_AB_CMD));
        $display("test client abort done");
    endtask
    task automatic t_err();
        xfer("badcmd", mk(8'he0, 16'h0, 0), mk(8'h80, 16'h0, SDO_AB_CMD));
        xfer("noidx", mk(8'h40, 16'h2000, 0), mk(8'h80, 16'h2000, SDO_AB_NO_OBJ));
        xfer("errcnt", mk(8'h2f, 16'h1003, 5), mk(8'h80, 16'h1003, SDO_AB_HIGH));
        xfer("exp", mk(8'h40, 16'h6041, 0), mk(8'h4b, 16'h6041, 32'h240));
        xfer("ca", mk(8'h50, 16'h6041, 0), mk(8'h80, 16'h6041, SDO_AB_ACCESS));
        xfer("big", mk(8'h40, 16'h2001, 0), mk(8'h80, 16'h2001, SDO_AB_GENERAL));
        xfer("long", mk(8'h23, 16'h2003, 1), mk(8'h80, 16'h2003, SDO_AB_LONG));
        xfer("nomap", mk(8'h23, 16'h2004, 1), mk(8'h80, 16'h2004, SDO_AB_NO_MAP));
        xfer("wr", mk(8'h2b, 16'h6040, 32'hf), mk(8'h60, 16'h6040, 0));
        nmt_operational = 1;
        xfer("opwr", mk(8'h23, 16'h1400, 1), mk(8'h80, 16'h1400, SDO_AB_STATE));
        nmt_operational = 0;
        node = 7'h05;
        xfer("node", mk(8'h40, 16'h6041, 0), mk(8'h4b, 16'h6041, 32'h240));
        $display("test aborts done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // load the upload image while reset is held, 20 cycles in all
    initial begin
        for (int k = 0; k < 17; k++) begin
            @(negedge mclk);
            ld_we = 1;
            ld_addr = 8'(k);
            ld_data = 8'h10 + 8'(k);
        end
        @(negedge mclk);
        ld_we = 0;
        repeat (2) @(negedge mclk);
        reset_n = 1;
        t_seg();
        t_tog();
        t_cabort();
        t_err();
        results();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        results();
    end
endmodule
`default_nettype wire
